// ---- sbl_pkg.sv ----
package sbl_pkg;
    // one state is one REF_CLK cycle (4 ns at 250 MHz)
    localparam int unsigned STARTUP_STATES = 100;
    localparam int unsigned MODE_SETUP_STATES = 4;
    localparam int unsigned STARTUP_CYCLES = STARTUP_STATES * 1;
    localparam int unsigned MODE_SAMPLE_CYCLES = MODE_SETUP_STATES * 1;
    localparam int unsigned STARTUP_W = $clog2(STARTUP_CYCLES + 1);

    // serial framing and measurement
    localparam int unsigned DATA_BITS = 8;
    localparam int unsigned FRAME_BITS = 10;
    localparam int unsigned BIT_W = 4;
    localparam int unsigned ZERO_LOW_BITS = 9;
    localparam int unsigned NINE_W = 4;
    localparam int unsigned DIV_W = 16;
    localparam int unsigned LEN_W = 16;
    localparam int unsigned FIFO_DEPTH = 2;

    // handshake bytes
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_SYNC = 8'h55;
    localparam logic [7:0] BYTE_ACK = 8'hAA;
    localparam logic [7:0] BYTE_FAIL = 8'hFF;

    // mode pins {high, low, c, b, a} that select boot mode
    localparam logic [4:0] BOOT_PATTERN = 5'h07;

    // download area
    localparam logic [23:0] RAM_START_ADDR = 24'hFF_E080;
    localparam logic [23:0] RAM_END_ADDR = 24'hFF_E87F;
    localparam logic [23:0] ID_END_ADDR = 24'hFF_E087;
    localparam logic [23:0] ENTRY_ADDR = 24'hFF_E088;
    localparam int unsigned RAM_BYTES = int'(RAM_END_ADDR - RAM_START_ADDR) + 1;
    localparam int unsigned RAM_AW = $clog2(RAM_BYTES);
    localparam int unsigned ID_BYTES = int'(ID_END_ADDR - RAM_START_ADDR) + 1;

    typedef enum logic [3:0] {
        ST_RESET_WAIT, ST_MEASURE, ST_LOW, ST_SEND_ZERO, ST_WAIT_SYNC, ST_LEN_HI, ST_LEN_LO,
        ST_DATA, ST_ERASE_CHECK, ST_ERASE_WAIT, ST_REPORT, ST_DRAIN, ST_BRANCH, ST_ABORT, ST_USER
    } sbl_state_t;
endpackage : sbl_pkg

// ---- sbl_ram.sv ----
`timescale 1ns/1ps
module sbl_ram #(
    parameter int unsigned AW = 11,
    parameter int unsigned DEPTH = 2048,
    parameter int unsigned DW = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [AW-1:0] waddr,
    input wire logic [DW-1:0] wdata,
    input wire logic [AW-1:0] raddr,
    output logic [DW-1:0] rdata_ff
);
    logic [DW-1:0] mem [DEPTH];

    // write port and registered read port
    always_ff @(posedge clk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
        rdata_ff <= mem[raddr];
    end
endmodule : sbl_ram

// ---- sbl_loader.sv ----
// How it works
// - boot mode when both mode inputs low and three boot-select pins high
// - boot-select pins released for general use once boot mode is active
// - flash erased only if not blank; blank flash left untouched
// - serial frames are 8 data bits, one stop bit, no parity
// - low time of zero bytes sets the bit-rate divisor
// - measurement starts about 100 states after reset release
// - one zero byte sent when bit-rate matching ends
// - 0x55 answered with one 0xAA byte
// - two length bytes, high first, both echoed
// - each program byte echoed; the first 2048 stored in order into download RAM
// - first eight downloaded bytes checked against the identification code
// - after download erase check; 0xAA on success, 0xFF and abort on failure
// - before branching receive and transmit disabled, divisor kept, line high
// - watchdog overflow leaves boot mode
// - interrupts held disabled while erasing
// - flash reads inhibited while erasing
`timescale 1ns/1ps
module sbl_loader
    import sbl_pkg::*;
#(
    parameter logic [63:0] ID_CODE = 64'h0123_4567_89AB_CDEF // arbitrary value
) (
    input wire logic REF_CLK,
    input wire logic RST_N,
    input wire logic MODE_SELECT_LOW,
    input wire logic MODE_SELECT_HIGH,
    input wire logic BOOT_SELECT_PIN_A,
    input wire logic BOOT_SELECT_PIN_B,
    input wire logic BOOT_SELECT_PIN_C,
    input wire logic BOOT_SERIAL_RX,
    input wire logic WATCHDOG_OVERFLOW,
    input wire logic FLASH_BLANK,
    input wire logic FLASH_ERASE_DONE,
    input wire logic FLASH_ERASE_OK,
    input wire logic [sbl_pkg::RAM_AW-1:0] RAM_RD_ADDR,
    output logic [7:0] RAM_RD_DATA,
    output logic BOOT_SERIAL_TX,
    output logic BOOT_MODE,
    output logic BOOT_PINS_RELEASED,
    output logic [sbl_pkg::DIV_W-1:0] BIT_RATE_DIVISOR,
    output logic RECEIVE_ENABLE_BIT,
    output logic TRANSMIT_ENABLE_BIT,
    output logic FLASH_ERASE_REQ,
    output logic FLASH_READ_INHIBIT,
    output logic IRQ_DISABLE,
    output logic BRANCH_REQ,
    output logic [23:0] BRANCH_ADDR,
    output logic BOOT_ABORT,
    output logic RX_OVERRUN
);
    import sbl_pkg::*;

    localparam logic [DIV_W-1:0] DIV_ONE = DIV_W'(1);
    localparam logic [STARTUP_W-1:0] MODE_SAMPLE = STARTUP_W'(MODE_SAMPLE_CYCLES);
    localparam logic [STARTUP_W-1:0] STARTUP_LAST = STARTUP_W'(STARTUP_CYCLES - 1);
    localparam logic [NINE_W-1:0] NINE_LAST = NINE_W'(ZERO_LOW_BITS - 1);
    localparam logic [BIT_W-1:0] STOP_BIT = BIT_W'(FRAME_BITS - 1);
    localparam logic [LEN_W-1:0] LEN_ONE = LEN_W'(1);

    logic rx_meta_ff, rx_sync_ff;
    logic [4:0] mode_meta_ff, mode_sync_ff;
    sbl_state_t state_ff, nxt_state;
    logic [STARTUP_W-1:0] cnt_ff, nxt_cnt;
    logic boot_ff, nxt_boot, rel_ff, nxt_rel;
    logic [DIV_W-1:0] div_ff, nxt_div;
    logic [NINE_W-1:0] nine_ff, nxt_nine;
    logic re_ff, nxt_re, te_ff, nxt_te;
    logic [LEN_W-1:0] len_ff, nxt_len, idx_ff, nxt_idx;
    logic [63:0] id_shift_ff, nxt_id_shift;
    logic id_bad_ff, nxt_id_bad, fail_ff, nxt_fail;
    logic erase_ff, nxt_erase, inh_ff, nxt_inh, irq_ff, nxt_irq;
    logic branch_ff, nxt_branch, abort_ff, nxt_abort;
    logic tx_start, pop, ram_we, tx_free, take;
    logic [7:0] tx_byte;
    logic rx_busy_ff, nxt_rx_busy, rx_valid_ff, nxt_rx_valid;
    logic [DIV_W-1:0] rx_cnt_ff, nxt_rx_cnt, tx_cnt_ff, nxt_tx_cnt;
    logic [BIT_W-1:0] rx_bit_ff, nxt_rx_bit, tx_bit_ff, nxt_tx_bit;
    logic [7:0] rx_shift_ff, nxt_rx_shift;
    logic tx_busy_ff, nxt_tx_busy, tx_line_ff, nxt_tx_line;
    logic [8:0] tx_shift_ff, nxt_tx_shift;
    logic [7:0] fifo_mem_ff [FIFO_DEPTH];
    logic [7:0] nxt_fifo_mem [FIFO_DEPTH];
    logic fifo_wr_ff, nxt_fifo_wr, fifo_rd_ff, nxt_fifo_rd, ovr_ff, nxt_ovr;
    logic [1:0] fifo_cnt_ff, nxt_fifo_cnt;
    logic fifo_valid, fifo_in_ready;
    logic [7:0] fifo_data;

    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RST_N);

    // pin synchronisers
    always_ff @(posedge REF_CLK) begin
        rx_meta_ff <= BOOT_SERIAL_RX;
        rx_sync_ff <= rx_meta_ff;
        mode_meta_ff <= {MODE_SELECT_HIGH, MODE_SELECT_LOW, BOOT_SELECT_PIN_C, BOOT_SELECT_PIN_B, BOOT_SELECT_PIN_A};
        mode_sync_ff <= mode_meta_ff;
    end

    // serial receiver, sampling mid-bit at the measured rate
    always_comb begin
        nxt_rx_busy = rx_busy_ff;
        nxt_rx_cnt = rx_cnt_ff;
        nxt_rx_bit = rx_bit_ff;
        nxt_rx_shift = rx_shift_ff;
        nxt_rx_valid = 1'b0;
        if (!re_ff) begin
            nxt_rx_busy = 1'b0;
        end else if (!rx_busy_ff) begin
            if (!rx_sync_ff) begin
                nxt_rx_busy = 1'b1;
                nxt_rx_cnt = div_ff >> 1;
                nxt_rx_bit = '0;
            end
        end else if (rx_cnt_ff != '0) begin
            nxt_rx_cnt = rx_cnt_ff - DIV_ONE;
        end else begin
            nxt_rx_cnt = div_ff - DIV_ONE;
            nxt_rx_bit = rx_bit_ff + 4'h1;
            if (rx_bit_ff == '0) begin
                nxt_rx_busy = !rx_sync_ff; // false start drops out
            end else if (rx_bit_ff <= BIT_W'(DATA_BITS)) begin
                nxt_rx_shift = {rx_sync_ff, rx_shift_ff[7:1]};
            end else begin
                nxt_rx_busy = 1'b0;
                nxt_rx_valid = rx_sync_ff; // framing error discards the byte
            end
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            rx_busy_ff <= 1'b0;
            rx_valid_ff <= 1'b0;
            rx_cnt_ff <= '0;
            rx_bit_ff <= '0;
            rx_shift_ff <= '0;
        end else begin
            rx_busy_ff <= nxt_rx_busy;
            rx_valid_ff <= nxt_rx_valid;
            rx_cnt_ff <= nxt_rx_cnt;
            rx_bit_ff <= nxt_rx_bit;
            rx_shift_ff <= nxt_rx_shift;
        end
    end

    // serial transmitter: start, eight data bits lsb first, stop
    always_comb begin
        nxt_tx_busy = tx_busy_ff;
        nxt_tx_cnt = tx_cnt_ff;
        nxt_tx_bit = tx_bit_ff;
        nxt_tx_shift = tx_shift_ff;
        nxt_tx_line = tx_line_ff;
        if (!te_ff) begin
            nxt_tx_busy = 1'b0;
            nxt_tx_line = 1'b1; // idle high after branch
        end else if (!tx_busy_ff) begin
            nxt_tx_line = 1'b1;
            if (tx_start) begin
                nxt_tx_busy = 1'b1;
                nxt_tx_shift = {1'b1, tx_byte};
                nxt_tx_cnt = div_ff - DIV_ONE;
                nxt_tx_bit = '0;
                nxt_tx_line = 1'b0;
            end
        end else if (tx_cnt_ff != '0) begin
            nxt_tx_cnt = tx_cnt_ff - DIV_ONE;
        end else if (tx_bit_ff == STOP_BIT) begin
            nxt_tx_busy = 1'b0;
        end else begin
            nxt_tx_cnt = div_ff - DIV_ONE;
            nxt_tx_bit = tx_bit_ff + 4'h1;
            nxt_tx_line = tx_shift_ff[0];
            nxt_tx_shift = {1'b1, tx_shift_ff[8:1]};
        end
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            tx_busy_ff <= 1'b0;
            tx_cnt_ff <= '0;
            tx_bit_ff <= '0;
            tx_shift_ff <= '1;
            tx_line_ff <= 1'b1;
        end else begin
            tx_busy_ff <= nxt_tx_busy;
            tx_cnt_ff <= nxt_tx_cnt;
            tx_bit_ff <= nxt_tx_bit;
            tx_shift_ff <= nxt_tx_shift;
            tx_line_ff <= nxt_tx_line;
        end
    end

    // two-entry buffer between receiver and sequencer
    assign fifo_valid = (fifo_cnt_ff != 2'h0);
    assign fifo_in_ready = (fifo_cnt_ff != 2'(FIFO_DEPTH));
    assign fifo_data = fifo_mem_ff[fifo_rd_ff];

    always_comb begin
        nxt_fifo_mem = fifo_mem_ff;
        nxt_fifo_wr = fifo_wr_ff;
        nxt_fifo_rd = fifo_rd_ff;
        nxt_fifo_cnt = fifo_cnt_ff;
        nxt_ovr = ovr_ff | (rx_valid_ff & !fifo_in_ready); // sticky until reset
        if (rx_valid_ff && fifo_in_ready) begin
            nxt_fifo_mem[fifo_wr_ff] = rx_shift_ff;
            nxt_fifo_wr = !fifo_wr_ff;
        end
        if (pop) begin
            nxt_fifo_rd = !fifo_rd_ff;
        end
        nxt_fifo_cnt = fifo_cnt_ff + {1'b0, rx_valid_ff & fifo_in_ready} - {1'b0, pop};
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            fifo_mem_ff <= '{default: '0};
            fifo_wr_ff <= 1'b0;
            fifo_rd_ff <= 1'b0;
            fifo_cnt_ff <= '0;
            ovr_ff <= 1'b0;
        end else begin
            fifo_mem_ff <= nxt_fifo_mem;
            fifo_wr_ff <= nxt_fifo_wr;
            fifo_rd_ff <= nxt_fifo_rd;
            fifo_cnt_ff <= nxt_fifo_cnt;
            ovr_ff <= nxt_ovr;
        end
    end

    // boot sequencer
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_boot = boot_ff;
        nxt_rel = rel_ff;
        nxt_div = div_ff;
        nxt_nine = nine_ff;
        nxt_re = re_ff;
        nxt_te = te_ff;
        nxt_len = len_ff;
        nxt_idx = idx_ff;
        nxt_id_shift = id_shift_ff;
        nxt_id_bad = id_bad_ff;
        nxt_fail = fail_ff;
        nxt_erase = erase_ff;
        nxt_branch = branch_ff;
        nxt_abort = abort_ff;
        tx_start = 1'b0;
        tx_byte = fifo_data; // echo by default
        pop = 1'b0;
        ram_we = 1'b0;
        tx_free = te_ff && !tx_busy_ff;
        take = fifo_valid && tx_free;
        case (state_ff)
            ST_RESET_WAIT: begin
                nxt_cnt = cnt_ff + STARTUP_W'(1);
                if (cnt_ff == MODE_SAMPLE) begin
                    if (mode_sync_ff == BOOT_PATTERN) begin
                        nxt_boot = 1'b1;
                        nxt_rel = 1'b1;
                    end else begin
                        nxt_state = ST_USER;
                    end
                end
                if (cnt_ff == STARTUP_LAST) begin
                    nxt_state = ST_MEASURE;
                end
            end
            ST_MEASURE: begin
                if (!rx_sync_ff) begin // line idles high from reset
                    nxt_state = ST_LOW;
                    nxt_div = '0;
                    nxt_nine = NINE_W'(1); // this first low cycle counts too
                end
            end
            ST_LOW: begin
                if (rx_sync_ff) begin
                    nxt_state = (div_ff != '0) ? ST_SEND_ZERO : ST_MEASURE;
                    nxt_re = (div_ff != '0);
                    nxt_te = (div_ff != '0);
                end else if (nine_ff == NINE_LAST) begin
                    nxt_nine = '0;
                    nxt_div = div_ff + DIV_ONE; // one cycle per nine of low time
                end else begin
                    nxt_nine = nine_ff + NINE_W'(1);
                end
            end
            ST_SEND_ZERO: begin
                if (tx_free) begin
                    tx_start = 1'b1;
                    tx_byte = BYTE_ZERO;
                    nxt_state = ST_WAIT_SYNC;
                end
            end
            ST_WAIT_SYNC: begin
                if (fifo_valid && fifo_data != BYTE_SYNC) begin
                    pop = 1'b1; // trailing zero bytes dropped
                end else if (take) begin
                    pop = 1'b1;
                    tx_start = 1'b1;
                    tx_byte = BYTE_ACK;
                    nxt_state = ST_LEN_HI;
                end
            end
            ST_LEN_HI: begin
                if (take) begin
                    pop = 1'b1;
                    tx_start = 1'b1;
                    nxt_len = {fifo_data, len_ff[7:0]};
                    nxt_state = ST_LEN_LO;
                end
            end
            ST_LEN_LO: begin
                if (take) begin
                    pop = 1'b1;
                    tx_start = 1'b1;
                    nxt_len = {len_ff[15:8], fifo_data};
                    nxt_idx = '0;
                    nxt_id_shift = ID_CODE;
                    nxt_id_bad = 1'b0;
                    nxt_state = ({len_ff[15:8], fifo_data} == '0) ? ST_ERASE_CHECK : ST_DATA;
                end
            end
            ST_DATA: begin
                if (take) begin
                    pop = 1'b1;
                    tx_start = 1'b1;
                    ram_we = (idx_ff < LEN_W'(RAM_BYTES)); // excess bytes echoed, not stored
                    if (idx_ff < LEN_W'(ID_BYTES)) begin
                        nxt_id_bad = id_bad_ff | (fifo_data != id_shift_ff[63:56]);
                        nxt_id_shift = {id_shift_ff[55:0], 8'h00};
                    end
                    nxt_idx = idx_ff + LEN_ONE;
                    if (idx_ff + LEN_ONE == len_ff) begin
                        nxt_state = ST_ERASE_CHECK;
                    end
                end
            end
            ST_ERASE_CHECK: begin
                nxt_state = ST_REPORT;
                if (id_bad_ff || idx_ff < LEN_W'(ID_BYTES)) begin
                    nxt_fail = 1'b1;
                end else if (FLASH_BLANK) begin
                    nxt_fail = 1'b0;
                end else begin
                    nxt_erase = 1'b1;
                    nxt_state = ST_ERASE_WAIT;
                end
            end
            ST_ERASE_WAIT: begin
                if (FLASH_ERASE_DONE) begin
                    nxt_erase = 1'b0;
                    nxt_fail = !FLASH_ERASE_OK;
                    nxt_state = ST_REPORT;
                end
            end
            ST_REPORT: begin
                if (tx_free) begin
                    tx_start = 1'b1;
                    tx_byte = fail_ff ? BYTE_FAIL : BYTE_ACK;
                    nxt_state = ST_DRAIN;
                end
            end
            ST_DRAIN: begin
                if (!tx_busy_ff) begin
                    nxt_re = 1'b0; // divisor stays as measured
                    nxt_te = 1'b0;
                    nxt_abort = fail_ff;
                    nxt_branch = !fail_ff;
                    nxt_state = fail_ff ? ST_ABORT : ST_BRANCH;
                end
            end
            ST_BRANCH, ST_ABORT, ST_USER: begin
                nxt_state = state_ff;
            end
            default: begin
                nxt_state = ST_USER;
            end
        endcase
        if (WATCHDOG_OVERFLOW && boot_ff) begin
            nxt_boot = 1'b0;
            nxt_re = 1'b0;
            nxt_te = 1'b0;
            nxt_erase = 1'b0;
            nxt_branch = 1'b0;
            nxt_state = ST_USER;
            tx_start = 1'b0;
            pop = 1'b0;
            ram_we = 1'b0;
        end
        nxt_inh = nxt_erase;
        nxt_irq = nxt_erase | (nxt_boot & !nxt_branch);
    end

    always_ff @(posedge REF_CLK) begin
        if (!RST_N) begin
            state_ff <= ST_RESET_WAIT;
            cnt_ff <= '0;
            boot_ff <= 1'b0;
            rel_ff <= 1'b0;
            div_ff <= '0;
            nine_ff <= '0;
            re_ff <= 1'b0;
            te_ff <= 1'b0;
            len_ff <= '0;
            idx_ff <= '0;
            id_shift_ff <= '0;
            id_bad_ff <= 1'b0;
            fail_ff <= 1'b0;
            erase_ff <= 1'b0;
            inh_ff <= 1'b0;
            irq_ff <= 1'b0;
            branch_ff <= 1'b0;
            abort_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            boot_ff <= nxt_boot;
            rel_ff <= nxt_rel;
            div_ff <= nxt_div;
            nine_ff <= nxt_nine;
            re_ff <= nxt_re;
            te_ff <= nxt_te;
            len_ff <= nxt_len;
            idx_ff <= nxt_idx;
            id_shift_ff <= nxt_id_shift;
            id_bad_ff <= nxt_id_bad;
            fail_ff <= nxt_fail;
            erase_ff <= nxt_erase;
            inh_ff <= nxt_inh;
            irq_ff <= nxt_irq;
            branch_ff <= nxt_branch;
            abort_ff <= nxt_abort;
        end
    end

    // download area
    sbl_ram #(.AW(RAM_AW), .DEPTH(RAM_BYTES), .DW(8)) u_ram (
        .clk(REF_CLK),
        .we(ram_we),
        .waddr(idx_ff[RAM_AW-1:0]),
        .wdata(fifo_data),
        .raddr(RAM_RD_ADDR),
        .rdata_ff(RAM_RD_DATA)
    );

    // outputs from flops, except BRANCH_ADDR which is the constant ENTRY_ADDR
    assign BOOT_SERIAL_TX = tx_line_ff;
    assign BOOT_MODE = boot_ff;
    assign BOOT_PINS_RELEASED = rel_ff;
    assign BIT_RATE_DIVISOR = div_ff;
    assign RECEIVE_ENABLE_BIT = re_ff;
    assign TRANSMIT_ENABLE_BIT = te_ff;
    assign FLASH_ERASE_REQ = erase_ff;
    assign FLASH_READ_INHIBIT = inh_ff;
    assign IRQ_DISABLE = irq_ff;
    assign BRANCH_REQ = branch_ff;
    assign BRANCH_ADDR = ENTRY_ADDR;
    assign BOOT_ABORT = abort_ff;
    assign RX_OVERRUN = ovr_ff;

    // checks
    mode_decode_a: assert property ((state_ff == ST_RESET_WAIT && cnt_ff == MODE_SAMPLE)
        |=> boot_ff == ($past(mode_sync_ff) == BOOT_PATTERN)) else $error("mode decode wrong");
    pins_release_a: assert property ($rose(boot_ff) |-> rel_ff) else $error("pins not released");
    blank_skip_a: assert property ((state_ff == ST_ERASE_CHECK && FLASH_BLANK && !id_bad_ff
        && idx_ff >= LEN_W'(ID_BYTES))
        |=> !erase_ff && state_ff == ST_REPORT && !fail_ff) else $error("blank flash erased");
    stop_bit_a: assert property ((tx_busy_ff && tx_bit_ff == STOP_BIT) |-> tx_line_ff) else $error("bad stop bit");
    div_count_a: assert property ((state_ff == ST_LOW && !rx_sync_ff && nine_ff == NINE_LAST)
        |=> div_ff == $past(div_ff) + DIV_ONE) else $error("divisor count wrong");
    ready_time_a: assert property ((state_ff == ST_RESET_WAIT && cnt_ff < STARTUP_LAST)
        |=> state_ff == ST_RESET_WAIT || state_ff == ST_USER) else $error("measure too early");
    zero_ind_a: assert property ((state_ff == ST_SEND_ZERO && tx_start)
        |-> tx_byte == BYTE_ZERO ##1 state_ff == ST_WAIT_SYNC && tx_busy_ff) else $error("no zero byte");
    sync_ack_a: assert property ((state_ff == ST_WAIT_SYNC && pop && fifo_data == BYTE_SYNC)
        |-> tx_start && tx_byte == BYTE_ACK) else $error("no ack to sync");
    echo_a: assert property ((pop && (state_ff == ST_LEN_HI || state_ff == ST_LEN_LO || state_ff == ST_DATA))
        |-> tx_start && tx_byte == fifo_data) else $error("byte not echoed");
    report_a: assert property ((state_ff == ST_REPORT && tx_start)
        |-> tx_byte == (fail_ff ? BYTE_FAIL : BYTE_ACK)) else $error("bad result byte");
    branch_off_a: assert property ($rose(branch_ff) |-> !re_ff && !te_ff && tx_line_ff && div_ff != '0)
        else $error("serial not stopped");
    wdt_exit_a: assert property ((WATCHDOG_OVERFLOW && boot_ff) |=> !boot_ff && state_ff == ST_USER)
        else $error("watchdog exit missed");
    erase_guard_a: assert property (erase_ff |-> inh_ff && irq_ff) else $error("erase unguarded");
    branch_c: cover property ($rose(branch_ff));
    abort_c: cover property ($rose(abort_ff));
    erase_c: cover property ($fell(erase_ff) && state_ff == ST_REPORT);
endmodule : sbl_loader

// ---- sbl_host.sv ----
`timescale 1ns/1ps
module sbl_host #(
    parameter int BIT = 16
) (
    input wire logic clk,
    input wire logic dev_tx,
    output logic dev_rx
);
    // line idle high from time zero
    initial dev_rx = 1'b1;
    // one frame: start, 8 data lsb first, one stop, no parity
    task automatic send_byte(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            @(posedge clk);
            #1;
            dev_rx = f[i];
            repeat (BIT - 1) @(posedge clk);
        end
    endtask : send_byte
    // bounded wait for a start bit, then mid-bit sampling
    task automatic recv_byte(output logic [7:0] b, output bit ok);
        int n;
        n = 0;
        while (dev_tx === 1'b1 && n < 5000) begin
            @(posedge clk);
            n++;
        end
        repeat (BIT / 2) @(posedge clk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT) @(posedge clk);
            b[i] = dev_tx;
        end
        repeat (BIT) @(posedge clk);
        ok = (n < 5000) && (dev_tx === 1'b1);
        #1;
    endtask : recv_byte
endmodule : sbl_host

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
    import sbl_pkg::*;
    localparam logic [63:0] ID = 64'h0123_4567_89AB_CDEF; // arbitrary value
    logic ref_clk = 0, rst_n = 0, msl = 0, msh = 0, pa = 1, pb = 1, pc = 1, wdt = 0;
    logic blank = 0, edone = 0, eok = 0, rx, tx, boot, rel, re, te, ereq, rinh, irqd, br, abrt, ovr;
    logic [RAM_AW-1:0] rd_addr = '0;
    logic [7:0] rd_data;
    logic [DIV_W-1:0] div;
    logic [23:0] baddr;
    int fails = 0, checked = 0;
    sbl_loader #(.ID_CODE(ID)) i_sbl_loader (.REF_CLK(ref_clk), .RST_N(rst_n), .MODE_SELECT_LOW(msl),
        .MODE_SELECT_HIGH(msh), .BOOT_SELECT_PIN_A(pa), .BOOT_SELECT_PIN_B(pb), .BOOT_SELECT_PIN_C(pc),
        .BOOT_SERIAL_RX(rx), .WATCHDOG_OVERFLOW(wdt), .FLASH_BLANK(blank), .FLASH_ERASE_DONE(edone),
        .FLASH_ERASE_OK(eok), .RAM_RD_ADDR(rd_addr), .RAM_RD_DATA(rd_data), .BOOT_SERIAL_TX(tx),
        .BOOT_MODE(boot), .BOOT_PINS_RELEASED(rel), .BIT_RATE_DIVISOR(div), .RECEIVE_ENABLE_BIT(re),
        .TRANSMIT_ENABLE_BIT(te), .FLASH_ERASE_REQ(ereq), .FLASH_READ_INHIBIT(rinh), .IRQ_DISABLE(irqd),
        .BRANCH_REQ(br), .BRANCH_ADDR(baddr), .BOOT_ABORT(abrt), .RX_OVERRUN(ovr));
    // 16 clocks per bit, a rate the divisor measures exactly
    sbl_host #(.BIT(16)) i_sbl_host (.clk(ref_clk), .dev_tx(tx), .dev_rx(rx));
    // 4 ns clock
    initial forever #2 ref_clk = ~ref_clk;
    task automatic conclude();
        if (fails == 0 && checked > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : conclude
    task automatic cmp(input logic [23:0] got, input logic [23:0] exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t got %h expected %h", $time, got, exp);
        end
    endtask : cmp
    // reset for 10 cycles (20 on later calls) with mode pins set, then past the startup delay
    task automatic start(input logic [4:0] p);
        @(posedge ref_clk);
        #1;
        rst_n = 0;
        {msh, msl, pc, pb, pa} = p;
        // later resets leave boot mode, which wants the longer hold
        repeat ((checked == 0) ? 10 : 20) @(posedge ref_clk);
        #1;
        rst_n = 1; // mode pins held from here on
        repeat (130) @(posedge ref_clk);
        #1;
    endtask : start
    task automatic xfer(input logic [7:0] b, input logic [7:0] e);
        logic [7:0] r;
        bit ok;
        fork
            i_sbl_host.send_byte(b);
            i_sbl_host.recv_byte(r, ok);
        join
        if (!ok) begin
            fails++;
            conclude();
        end
        cmp(r, e);
    endtask : xfer
    task automatic wait_for(ref logic s);
        for (int n = 0; n < 5000 && s !== 1'b1; n++) begin
            @(posedge ref_clk);
            #1;
        end
        if (s !== 1'b1) begin
            fails++;
            conclude();
        end
    endtask : wait_for
    task automatic sync_up(input logic [7:0] n);
        start(BOOT_PATTERN);
        cmp(boot, 1);
        cmp(rel, 1);
        xfer(BYTE_ZERO, BYTE_ZERO);
        cmp(div, 16);
        xfer(BYTE_SYNC, BYTE_ACK);
        xfer(8'h00, 8'h00);
        xfer(n, n);
    endtask : sync_up
    // full download, erase and branch
    task automatic s_boot();
        logic [7:0] r;
        bit ok;
        sync_up(8'h09);
        for (int k = 0; k < 8; k++) xfer(ID[63 - 8 * k -: 8], ID[63 - 8 * k -: 8]);
        xfer(8'hC3, 8'hC3); // entry byte; the loaded program sets up its own registers
        rd_addr = 11'h008;
        wait_for(ereq);
        @(posedge ref_clk);
        #1;
        cmp(rd_data, 8'hC3);
        cmp(rinh, 1);
        cmp(irqd, 1);
        eok = 1;
        edone = 1;
        @(posedge ref_clk);
        #1;
        edone = 0;
        i_sbl_host.recv_byte(r, ok);
        cmp({ok, r}, {1'b1, BYTE_ACK});
        wait_for(br);
        cmp({re, te, tx, abrt, ereq, rinh, irqd}, 7'h10);
        cmp(div, 16);
        cmp(baddr, ENTRY_ADDR);
    endtask : s_boot
    // too short to hold the identification block
    task automatic s_short();
        logic [7:0] r;
        bit ok;
        sync_up(8'h01);
        xfer(8'h5A, 8'h5A);
        i_sbl_host.recv_byte(r, ok);
        cmp({ok, r}, {1'b1, BYTE_FAIL});
        wait_for(abrt);
        cmp({br, ereq, ovr}, 3'b000);
    endtask : s_short
    // blank flash: no erase, straight to the acknowledge
    task automatic s_blank();
        logic [7:0] r;
        bit ok;
        blank = 1;
        sync_up(8'h08);
        for (int k = 0; k < 8; k++) xfer(ID[63 - 8 * k -: 8], ID[63 - 8 * k -: 8]);
        i_sbl_host.recv_byte(r, ok);
        cmp({ok, r}, {1'b1, BYTE_ACK});
        wait_for(br);
        cmp({ereq, abrt}, 2'b00);
        blank = 0;
    endtask : s_blank
    task automatic s_other();
        start(5'h10);
        cmp({boot, rel}, 2'b00);
        start(BOOT_PATTERN);
        wdt = 1;
        @(posedge ref_clk);
        #1;
        wdt = 0;
        @(posedge ref_clk);
        #1;
        cmp({boot, rel}, 2'b01);
    endtask : s_other
    initial begin
        s_boot();
        s_short();
        s_blank();
        s_other();
        cmp(ovr, 0);
        conclude();
    end
endmodule : testbench
